/* inc/fpa_cfg.svh */
`ifndef FPA_CFG_SVH
`define FPA_CFG_SVH

// ==================================================================
// Mode codes of the two-bit mode field.
`define FPA_MODE_OFF 2'h0
`define FPA_MODE_PART 2'h1
`define FPA_MODE_FULL 2'h2
`define FPA_MODE_RST 2'h0

// ==================================================================
// Fetch timing field: reset value and shortest usable count.
`define FPA_TIM_RST 3'h7
`define FPA_TIM_MIN 3'h1
`define FPA_TIM_ZERO 3'h0

// ==================================================================
// Line geometry and fetch address fields.
`define FPA_LINE_W 128
`define FPA_ADDR_W 18
`define FPA_BANK_BIT 4
`define FPA_LINE_LO 4
`define FPA_IDX_LO 5
`define FPA_WSEL_HI 3
`define FPA_WSEL_LO 2
`define FPA_HSEL_LO 1
`define FPA_LAST_WORD 2'h3
`define FPA_LAST_HALF 3'h7
`define FPA_WORD_W 32
`define FPA_HALF_W 16

`endif

/* inc/fpa_pkg.sv */
`include "fpa_cfg.svh"

// ==================================================================
// Shared types of the flash prefetch accelerator.
package fpa_pkg;

  // Sequencer states of the core-facing fetch logic.
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT} fpa_state_t;

  // Which holding latch a finished bank read is written into.
  typedef enum logic [1:0] {DEST_PF, DEST_BT, DEST_DT} fpa_dest_t;

endpackage : fpa_pkg

/* src/fpa_line_buf.sv */
`timescale 1ns/100ps

// ==================================================================
// One holding latch: a line, its comparison tag and a valid flag.
module fpa_line_buf #(
  parameter int TAG_W = 13,
  parameter int LINE_W = 128
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Control.
  input wire logic clear,
  input wire logic load,
  input wire logic [TAG_W-1:0] loadTag,
  input wire logic [LINE_W-1:0] loadData,
  // Lookup.
  input wire logic [TAG_W-1:0] cmpTag,
  output logic hit,
  output logic [LINE_W-1:0] lineData
);

  logic validReg;
  logic validNext;
  logic [TAG_W-1:0] tagReg;
  logic [TAG_W-1:0] tagNext;
  logic [LINE_W-1:0] dataReg;
  logic [LINE_W-1:0] dataNext;

  // Clear beats a load in the same cycle, so no stale line survives.
  always_comb
  begin
    validNext = validReg;
    tagNext = tagReg;
    dataNext = dataReg;
    if (clear)
    begin
      validNext = 1'b0;
    end
    else if (load)
    begin
      validNext = 1'b1;
      tagNext = loadTag;
      dataNext = loadData;
    end
  end

  // Latches start out empty.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      validReg <= 1'b0;
      tagReg <= '0;
      dataReg <= '0;
    end
    else
    begin
      validReg <= validNext;
      tagReg <= tagNext;
      dataReg <= dataNext;
    end
  end

  // A hit needs a valid line with the matching tag.
  assign hit = validReg && (tagReg == cmpTag);
  assign lineData = dataReg;

endmodule : fpa_line_buf

/* src/fpa_top.sv */
`timescale 1ns/100ps
`include "fpa_cfg.svh"

module fpa_top #(
  parameter int ADDR_W = `FPA_ADDR_W,
  parameter int LINE_W = `FPA_LINE_W
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Configuration and programming status.
  input wire logic [1:0] accelMode,
  input wire logic [2:0] fetchTiming,
  input wire logic progBusy,
  // Core fetch port.
  input wire logic reqValid,
  input wire logic reqInstr,
  input wire logic reqSeq,
  input wire logic reqHalf,
  input wire logic [ADDR_W-1:0] reqAddr,
  output logic rdReady,
  output logic [`FPA_WORD_W-1:0] rdData,
  // Flash bank 0.
  output logic flashRead0,
  output logic [ADDR_W-`FPA_IDX_LO-1:0] flashAddr0,
  input wire logic [LINE_W-1:0] flashRdData0,
  // Flash bank 1.
  output logic flashRead1,
  output logic [ADDR_W-`FPA_IDX_LO-1:0] flashAddr1,
  input wire logic [LINE_W-1:0] flashRdData1
);
  import fpa_pkg::*;

  localparam int NBANK = 2;
  localparam int IDX_W = ADDR_W - `FPA_IDX_LO;
  localparam int LTAG_W = ADDR_W - `FPA_LINE_LO;

  // ================================================================
  // Helpers.
  // Pick the addressed word, or halfword in the compressed state.
  function automatic logic [`FPA_WORD_W-1:0] pickItem(
    input logic [LINE_W-1:0] line,
    input logic [`FPA_WSEL_HI:`FPA_HSEL_LO] sel,
    input logic half
  );
    logic [`FPA_WORD_W-1:0] item;
    item = line[sel[`FPA_WSEL_HI:`FPA_WSEL_LO]*`FPA_WORD_W +: `FPA_WORD_W];
    if (half)
    begin
      item = {{`FPA_HALF_W{1'b0}}, line[sel*`FPA_HALF_W +: `FPA_HALF_W]};
    end
    return item;
  endfunction : pickItem

  // ================================================================
  // Configuration capture and invalidate detection.
  logic [1:0] modeReg;
  logic [1:0] modeNext;
  logic [2:0] timReg;
  logic [2:0] timNext;
  logic progPrevReg;
  logic progPrevNext;
  logic invalidate;
  logic modeFull;
  logic modePart;
  logic [2:0] fetchLen;

  // The fields follow their inputs; any mode change flushes.
  always_comb
  begin
    modeNext = accelMode;
    timNext = fetchTiming;
    progPrevNext = progBusy;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      modeReg <= `FPA_MODE_RST;
      timReg <= `FPA_TIM_RST;
      progPrevReg <= 1'b0;
    end
    else
    begin
      modeReg <= modeNext;
      timReg <= timNext;
      progPrevReg <= progPrevNext;
    end
  end

  // Reserved mode code acts as off; reserved timing code as one clock.
  assign modeFull = (modeReg == `FPA_MODE_FULL);
  assign modePart = (modeReg == `FPA_MODE_PART);
  assign fetchLen = (timReg == `FPA_TIM_ZERO) ? `FPA_TIM_MIN : timReg;
  assign invalidate = (accelMode != modeReg)
    || (progBusy && !progPrevReg);

  // ================================================================
  // Fetch address fields and latch lookups.
  logic tgtBank;
  logic [IDX_W-1:0] tgtIdx;
  logic [IDX_W-1:0] tgtIdxInc;
  logic [LINE_W-1:0] fData [NBANK];
  logic [LINE_W-1:0] btData [NBANK];
  logic [LINE_W-1:0] pfData [NBANK];
  logic [LINE_W-1:0] dtData;
  logic [LINE_W-1:0] dtLoadData;
  logic btHit [NBANK];
  logic pfHit [NBANK];
  logic dtHit;
  logic dtLoad;
  logic dtLoadBank;
  logic isLast;

  assign tgtBank = reqAddr[`FPA_BANK_BIT];
  assign tgtIdx = reqAddr[ADDR_W-1:`FPA_IDX_LO];
  assign tgtIdxInc = tgtIdx + 1'b1;
  assign fData[0] = flashRdData0;
  assign fData[1] = flashRdData1;
  assign isLast = reqHalf
    ? (reqAddr[`FPA_WSEL_HI:`FPA_HSEL_LO] == `FPA_LAST_HALF)
    : (reqAddr[`FPA_WSEL_HI:`FPA_WSEL_LO] == `FPA_LAST_WORD);

  // ================================================================
  // Bank read engines: one address latch and fetch counter per bank.
  logic bBusyReg [NBANK];
  logic bBusyNext [NBANK];
  logic [2:0] bCntReg [NBANK];
  logic [2:0] bCntNext [NBANK];
  logic [IDX_W-1:0] bIdxReg [NBANK];
  logic [IDX_W-1:0] bIdxNext [NBANK];
  fpa_dest_t bDestReg [NBANK];
  fpa_dest_t bDestNext [NBANK];
  logic bDone [NBANK];
  logic dmdStart [NBANK];
  logic [IDX_W-1:0] dmdIdx [NBANK];
  fpa_dest_t dmdDest;
  logic pfStart [NBANK];

  // A demand read preempts a prefetch; a prefetch starts only on an idle or finishing bank.
  always_comb
  begin
    for (int b = 0; b < NBANK; b++)
    begin
      bBusyNext[b] = bBusyReg[b];
      bCntNext[b] = bCntReg[b];
      bIdxNext[b] = bIdxReg[b];
      bDestNext[b] = bDestReg[b];
      if (bBusyReg[b])
      begin
        bCntNext[b] = bCntReg[b] - 1'b1;
        bBusyNext[b] = !bDone[b];
      end
      if (invalidate)
      begin
        bBusyNext[b] = 1'b0;
      end
      else if (dmdStart[b])
      begin
        bBusyNext[b] = 1'b1;
        bCntNext[b] = fetchLen;
        bIdxNext[b] = dmdIdx[b];
        bDestNext[b] = dmdDest;
      end
      else if (pfStart[b] && (!bBusyReg[b] || bDone[b]) && !progBusy)
      begin
        bBusyNext[b] = 1'b1;
        bCntNext[b] = fetchLen;
        bIdxNext[b] = tgtIdxInc;
        bDestNext[b] = DEST_PF;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int b = 0; b < NBANK; b++)
      begin
        bBusyReg[b] <= 1'b0;
        bCntReg[b] <= `FPA_TIM_RST;
        bIdxReg[b] <= '0;
        bDestReg[b] <= DEST_PF;
      end
    end
    else
    begin
      bBusyReg <= bBusyNext;
      bCntReg <= bCntNext;
      bIdxReg <= bIdxNext;
      bDestReg <= bDestNext;
    end
  end

  assign flashRead0 = bBusyReg[0];
  assign flashRead1 = bBusyReg[1];
  assign flashAddr0 = bIdxReg[0];
  assign flashAddr1 = bIdxReg[1];

  // Each bank owns a trail and a prefetch latch; data has one shared.
  for (genvar g = 0; g < NBANK; g++)
  begin : gBank
    assign bDone[g] = bBusyReg[g] && (bCntReg[g] == `FPA_TIM_MIN);
    fpa_line_buf #(.TAG_W(IDX_W), .LINE_W(LINE_W)) uTrail (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .clear(invalidate),
      .load(bDone[g] && (bDestReg[g] == DEST_BT)),
      .loadTag(bIdxReg[g]),
      .loadData(fData[g]),
      .cmpTag(tgtIdx),
      .hit(btHit[g]),
      .lineData(btData[g])
    );
    fpa_line_buf #(.TAG_W(IDX_W), .LINE_W(LINE_W)) uPref (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .clear(invalidate),
      .load(bDone[g] && (bDestReg[g] == DEST_PF)),
      .loadTag(bIdxReg[g]),
      .loadData(fData[g]),
      .cmpTag(tgtIdx),
      .hit(pfHit[g]),
      .lineData(pfData[g])
    );
  end

  assign dtLoadBank = !(bDone[0] && (bDestReg[0] == DEST_DT));
  assign dtLoad = bDone[dtLoadBank] && (bDestReg[dtLoadBank] == DEST_DT);
  assign dtLoadData = fData[dtLoadBank];

  fpa_line_buf #(.TAG_W(LTAG_W), .LINE_W(LINE_W)) uData (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clear(invalidate),
    .load(dtLoad),
    .loadTag({bIdxReg[dtLoadBank], dtLoadBank}),
    .loadData(dtLoadData),
    .cmpTag(reqAddr[ADDR_W-1:`FPA_LINE_LO]),
    .hit(dtHit),
    .lineData(dtData)
  );

  // ================================================================
  // Core-facing sequencer. Programming itself is not handled here.
  fpa_state_t stReg;
  fpa_state_t stNext;
  logic waitBankReg;
  logic waitBankNext;
  logic rdReadyReg;
  logic rdReadyNext;
  logic [`FPA_WORD_W-1:0] rdDataReg;
  logic [`FPA_WORD_W-1:0] rdDataNext;
  logic useLatch;
  logic covered;

  assign useLatch = modeFull || (modePart && reqSeq);
  assign covered = bBusyReg[tgtBank] && (bDestReg[tgtBank] == DEST_PF)
    && (bIdxReg[tgtBank] == tgtIdx);

  // The answer cycle itself is skipped so a held request is not retaken.
  always_comb
  begin
    stNext = stReg;
    waitBankNext = waitBankReg;
    rdReadyNext = 1'b0;
    rdDataNext = rdDataReg;
    dmdDest = reqInstr ? DEST_BT : DEST_DT;
    for (int b = 0; b < NBANK; b++)
    begin
      dmdStart[b] = 1'b0;
      pfStart[b] = 1'b0;
      dmdIdx[b] = tgtIdx;
    end
    // The partner line is in bank 1 at the same index, or in bank 0 next.
    dmdIdx[0] = tgtBank ? tgtIdxInc : tgtIdx;
    case (stReg)
      ST_IDLE:
      begin
        if (reqValid && !invalidate && !progBusy && !rdReadyReg)
        begin
          if (reqInstr && useLatch && btHit[tgtBank])
          begin
            rdReadyNext = 1'b1;
            rdDataNext = pickItem(btData[tgtBank],
              reqAddr[`FPA_WSEL_HI:`FPA_HSEL_LO], reqHalf);
            pfStart[tgtBank] = isLast;
          end
          else if (reqInstr && useLatch && pfHit[tgtBank])
          begin
            rdReadyNext = 1'b1;
            rdDataNext = pickItem(pfData[tgtBank],
              reqAddr[`FPA_WSEL_HI:`FPA_HSEL_LO], reqHalf);
            pfStart[tgtBank] = isLast;
          end
          else if (reqInstr && useLatch && covered)
          begin
            waitBankNext = tgtBank;
            stNext = ST_WAIT;
          end
          else if (!reqInstr && modeFull && dtHit)
          begin
            rdReadyNext = 1'b1;
            rdDataNext = pickItem(dtData,
              reqAddr[`FPA_WSEL_HI:`FPA_HSEL_LO], reqHalf);
          end
          else
          begin
            dmdStart[tgtBank] = 1'b1;
            dmdStart[!tgtBank] = reqInstr;
            waitBankNext = tgtBank;
            stNext = ST_WAIT;
          end
        end
      end
      ST_WAIT:
      begin
        if (invalidate)
        begin
          stNext = ST_IDLE;
        end
        else if (bDone[waitBankReg])
        begin
          rdReadyNext = 1'b1;
          rdDataNext = pickItem(fData[waitBankReg],
            reqAddr[`FPA_WSEL_HI:`FPA_HSEL_LO], reqHalf);
          // Only code fetches, outside the off mode, look ahead.
          pfStart[waitBankReg] = reqInstr && isLast
            && (modeFull || modePart);
          stNext = ST_IDLE;
        end
      end
      default:
      begin
        stNext = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      stReg <= ST_IDLE;
      waitBankReg <= 1'b0;
      rdReadyReg <= 1'b0;
      rdDataReg <= '0;
    end
    else
    begin
      stReg <= stNext;
      waitBankReg <= waitBankNext;
      rdReadyReg <= rdReadyNext;
      rdDataReg <= rdDataNext;
    end
  end

  assign rdReady = rdReadyReg;
  assign rdData = rdDataReg;

endmodule : fpa_top

/* dv/fpa_flash_model.sv */
`timescale 1ns/100ps

// ==============================================================
// Two flash banks: a line shows only while its bank is read.
module fpa_flash_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Bank read strobes and line indices.
  input wire logic flashRead0,
  input wire logic [12:0] flashAddr0,
  input wire logic flashRead1,
  input wire logic [12:0] flashAddr1,
  // Line data back to the accelerator.
  output logic [127:0] flashRdData0,
  output logic [127:0] flashRdData1
);
  logic [127:0] junkReg;

  // Idle banks toggle every cycle, so a stale sample never matches.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      junkReg <= {32{4'h9}};
    else
      junkReg <= ~junkReg;
  end

  // Each word carries its bank, slot and index, so misrouting shows.
  always_comb
  begin
    for (int n = 0; n < 4; n++)
    begin
      flashRdData0[32*n+:32] = {3'h5, 1'b0, 2'(n), flashAddr0, 13'h0A5};
      flashRdData1[32*n+:32] = {3'h5, 1'b1, 2'(n), flashAddr1, 13'h0A5};
    end
    if (!flashRead0)
      flashRdData0 = junkReg;
    if (!flashRead1)
      flashRdData1 = junkReg;
  end
endmodule : fpa_flash_model

/* dv/fpa_top_props.sv */
`timescale 1ns/100ps
`include "fpa_cfg.svh"

// ==============================================================
// Port checks of the flash prefetch accelerator.
module fpa_top_props #(
  parameter int ADDR_W = `FPA_ADDR_W,
  parameter int LINE_W = `FPA_LINE_W
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Configuration and programming status.
  input wire logic [1:0] accelMode,
  input wire logic [2:0] fetchTiming,
  input wire logic progBusy,
  // Core fetch port.
  input wire logic reqValid,
  input wire logic reqInstr,
  input wire logic reqSeq,
  input wire logic reqHalf,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic rdReady,
  input wire logic [`FPA_WORD_W-1:0] rdData,
  // Flash banks.
  input wire logic flashRead0,
  input wire logic [ADDR_W-`FPA_IDX_LO-1:0] flashAddr0,
  input wire logic [LINE_W-1:0] flashRdData0,
  input wire logic flashRead1,
  input wire logic [ADDR_W-`FPA_IDX_LO-1:0] flashAddr1,
  input wire logic [LINE_W-1:0] flashRdData1
);
  // Bank line index width; differences wrap at the top of the bank.
  localparam int IDX_W = ADDR_W - `FPA_IDX_LO;

  // One clock domain; reset silences every check.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // An answer is one cycle long and follows a held request.
  property p_pulse;
    rdReady |=> !rdReady;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("answer pulse longer than one cycle");
  property p_cause;
    rdReady |-> $past(reqValid);
  endproperty
  a_cause: assert property (p_cause)
    else $error("answer without a request");

  // Leaving reset shows an idle port and quiet banks.
  property p_reset;
    $rose(nrst) |-> !rdReady && !flashRead0 && !flashRead1
      && rdData == '0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs busy right after reset");

  // Programming stalls the core and the banks alike.
  property p_stall;
    progBusy [*3] |-> !rdReady && !flashRead0 && !flashRead1;
  endproperty
  a_stall: assert property (p_stall)
    else $error("activity while programming runs");

  // A mode change drops whatever read was about to finish.
  property p_modeInv;
    $changed(accelMode) |=> !rdReady;
  endproperty
  a_modeInv: assert property (p_modeInv)
    else $error("answer right after a mode change");

  // Off and reserved modes answer only after a real bank read.
  property p_offFetch;
    rdReady && $stable(accelMode) && accelMode[1] == accelMode[0]
      |-> $past(flashRead0) || $past(flashRead1);
  endproperty
  a_offFetch: assert property (p_offFetch)
    else $error("latched answer while acceleration is off");

  // Data answers never launch a speculative read.
  property p_dataNoPf;
    rdReady && !reqInstr |=> !$rose(flashRead0) && !$rose(flashRead1);
  endproperty
  a_dataNoPf: assert property (p_dataNoPf)
    else $error("prefetch after a data read");

  // Both banks start together only on a code miss, on adjacent lines.
  property p_pairInstr;
    $rose(flashRead0) && $rose(flashRead1) |-> reqInstr;
  endproperty
  a_pairInstr: assert property (p_pairInstr)
    else $error("dual bank read for a data access");
  property p_pairAddr;
    $rose(flashRead0) && $rose(flashRead1)
      |-> IDX_W'(flashAddr0 - flashAddr1) <= 1;
  endproperty
  a_pairAddr: assert property (p_pairAddr)
    else $error("bank indices of a code miss not adjacent");

  // Main scenarios reached.
  c_dataAns: cover property (rdReady && !reqInstr);
  c_pair: cover property ($rose(flashRead0) && $rose(flashRead1));
  c_stall: cover property (progBusy && reqValid);
endmodule : fpa_top_props

bind fpa_top fpa_top_props #(.ADDR_W(ADDR_W), .LINE_W(LINE_W)) u_props (
  .clk_sys(clk_sys), .nrst(nrst), .accelMode(accelMode),
  .fetchTiming(fetchTiming), .progBusy(progBusy), .reqValid(reqValid),
  .reqInstr(reqInstr), .reqSeq(reqSeq), .reqHalf(reqHalf),
  .reqAddr(reqAddr), .rdReady(rdReady), .rdData(rdData),
  .flashRead0(flashRead0), .flashAddr0(flashAddr0),
  .flashRdData0(flashRdData0), .flashRead1(flashRead1),
  .flashAddr1(flashAddr1), .flashRdData1(flashRdData1)
);

/* dv/flash_prefetch_accelerator_tb.sv */
`timescale 1ns/100ps

// ==============================================================
// Directed bench of the flash prefetch accelerator.
module flash_prefetch_accelerator_tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] accelMode = 2'h0;
  logic [2:0] fetchTiming = 3'h7;
  logic progBusy = 1'b0;
  logic reqValid = 1'b0;
  logic reqInstr = 1'b0;
  logic reqSeq = 1'b0;
  logic reqHalf = 1'b0;
  logic [17:0] reqAddr = 18'h00000;
  logic rdReady, flashRead0, flashRead1;
  logic [31:0] rdData;
  logic [12:0] flashAddr0, flashAddr1;
  logic [127:0] flashRdData0, flashRdData1;
  int numErrors = 0;
  int compares = 0;

  // Free-running 40 MHz clock.
  always #12.5 clk_sys = ~clk_sys;

  // ==============================================================
  // Design and flash banks.
  fpa_top u_dut (
    .clk_sys(clk_sys), .nrst(nrst), .accelMode(accelMode),
    .fetchTiming(fetchTiming), .progBusy(progBusy), .reqValid(reqValid),
    .reqInstr(reqInstr), .reqSeq(reqSeq), .reqHalf(reqHalf),
    .reqAddr(reqAddr), .rdReady(rdReady), .rdData(rdData),
    .flashRead0(flashRead0), .flashAddr0(flashAddr0),
    .flashRdData0(flashRdData0), .flashRead1(flashRead1),
    .flashAddr1(flashAddr1), .flashRdData1(flashRdData1)
  );
  fpa_flash_model u_flash (
    .clk_sys(clk_sys), .nrst(nrst),
    .flashRead0(flashRead0), .flashAddr0(flashAddr0),
    .flashRead1(flashRead1), .flashAddr1(flashAddr1),
    .flashRdData0(flashRdData0), .flashRdData1(flashRdData1)
  );

  // ==============================================================
  // Helpers.
  task automatic summarize();
    $display("errors %0d, compares %0d", numErrors, compares);
    if (numErrors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic chkD(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      numErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkD

  task automatic chkN(input int got, input int exp);
    compares++;
    if (got != exp)
    begin
      numErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkN

  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : idle

  // Mode and timing change only while idle; three cycles let it settle.
  task automatic cfg(input int m, input int t);
    accelMode = 2'(m);
    fetchTiming = 3'(t);
    idle(3);
  endtask : cfg

  // One access to line l, item w; k is {instr, seq, half}.
  // The latency counts edges from presenting to the answer cycle.
  task automatic ftch(input logic [2:0] k, input int l, input int w,
      input int lat);
    int n;
    int wd;
    logic [31:0] e;
    wd = w >> k[0];
    e = {3'h5, l[0], wd[1:0], l[13:1], 13'h0A5};
    if (k[0])
      e = {16'h0000, w[0] ? e[31:16] : e[15:0]};
    {reqInstr, reqSeq, reqHalf} = k;
    reqAddr = k[0] ? {l[13:0], w[2:0], 1'b0} : {l[13:0], w[1:0], 2'h0};
    reqValid = 1'b1;
    n = 0;
    while (n < 40 && rdReady !== 1'b1)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 40)
    begin
      numErrors++;
      summarize();
    end
    else
    begin
      chkN(n, lat);
      chkD(rdData, e);
      idle(1);
      reqValid = 1'b0;
      idle(1);
    end
  endtask : ftch

  // ==============================================================
  // Scenarios.
  task automatic t_reset();
    chkD(rdData, 32'h0);
    chkD({29'h0, rdReady, flashRead0, flashRead1}, 32'h0);
  endtask : t_reset

  // Off and reserved modes: every access reads, for 1, 4 and 7 clocks.
  task automatic t_off();
    for (int m = 0; m < 4; m += 3)
      for (int t = 1; t < 8; t += 3)
      begin
        cfg(m, t);
        ftch(3'h6, 'h20, 2, t + 1);
        ftch(3'h6, 'h20, 2, t + 1);
      end
  endtask : t_off

  task automatic t_full();
    cfg(2, 2);
    ftch(3'h6, 'h42, 0, 3);
    ftch(3'h6, 'h42, 1, 1);
    ftch(3'h7, 'h42, 5, 1);
    ftch(3'h6, 'h43, 0, 1);
    ftch(3'h6, 'h42, 3, 1);
    idle(4);
    ftch(3'h4, 'h44, 0, 1);
    ftch(3'h6, 'h43, 3, 1);
    idle(4);
    ftch(3'h6, 'h45, 0, 1);
    ftch(3'h6, 'hA1, 1, 3);
    ftch(3'h6, 'hA2, 0, 1);
    // A slow prefetch still running makes the next line wait for it.
    cfg(2, 4);
    ftch(3'h6, 'hA2, 3, 1);
    ftch(3'h6, 'hA4, 0, 2);
    cfg(2, 2);
  endtask : t_full

  task automatic t_data();
    ftch(3'h0, 'h200, 1, 3);
    ftch(3'h0, 'h200, 3, 1);
    ftch(3'h4, 'h200, 0, 3);
    ftch(3'h0, 'h300, 3, 3);
    idle(4);
    ftch(3'h6, 'h302, 0, 3);
  endtask : t_data

  // Partial mode: only sequential code may use the latches.
  task automatic t_part();
    cfg(1, 2);
    ftch(3'h6, 'h302, 1, 3);
    ftch(3'h6, 'h302, 2, 1);
    ftch(3'h4, 'h302, 2, 3);
    ftch(3'h0, 'h302, 0, 3);
    ftch(3'h0, 'h302, 0, 3);
    cfg(2, 2);
  endtask : t_part

  // The request waits out programming, and the data latch is emptied.
  task automatic t_prog();
    ftch(3'h0, 'h400, 0, 3);
    ftch(3'h0, 'h400, 1, 1);
    progBusy = 1'b1;
    idle(2);
    fork
      begin
        repeat (5) @(posedge clk_sys);
        #1;
        progBusy = 1'b0;
      end
    join_none
    ftch(3'h4, 'h410, 0, 8);
    ftch(3'h0, 'h400, 1, 3);
  endtask : t_prog

  // ==============================================================
  // Main sequence.
  initial
  begin
    repeat (2) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    t_reset();
    t_off();
    t_full();
    t_data();
    t_part();
    t_prog();
    summarize();
  end
endmodule : flash_prefetch_accelerator_tb
